/* hdl/framer_status_pkg.sv */
// Purpose: shared constants for the framer channel status, test and interrupt registers
// Assumes: apb with 32-bit data, one aligned word per register
// Notes:   register data are 8 bits wide in the low byte
`default_nettype none
package framer_status_pkg;
    localparam logic [7:0] ADDR_BLOCK_IRQ_ENABLE = 8'h04;
    localparam logic [7:0] ADDR_BLOCK_IRQ_STATUS = 8'h08;
    localparam logic [7:0] ADDR_TEST_CONTROL     = 8'h0c;
    localparam logic [7:0] ADDR_RX_CONFIG_STATUS = 8'h10;
    localparam logic [7:0] ADDR_BLOCK_IRQ_CLEAR  = 8'h14;

    localparam int BIT_RX_IRQ       = 7;
    localparam int BIT_TX_IRQ       = 1;
    localparam int BIT_ONE_SEC      = 0;
    localparam int BIT_OH_SELECT    = 7;
    localparam int BIT_RX_GAPPED    = 6;
    localparam int BIT_TX_PAYCLK    = 5;
    localparam int BIT_PAT_LOCK     = 4;
    localparam int BIT_PAT_RX_EN    = 3;
    localparam int BIT_PAT_GEN_EN   = 2;
    localparam int BIT_ALARM        = 7;
    localparam int BIT_LOS          = 6;
    localparam int BIT_IDLE         = 5;
    localparam int BIT_OOF          = 4;

    localparam logic [7:0] IRQ_ENABLE_MASK  = 8'h83;
    localparam logic [7:0] TEST_WRITE_MASK  = 8'hec;
    localparam logic [7:0] RX_CFG_WRITE_MASK = 8'h07;
    localparam logic [7:0] RESET_VALUE      = 8'h00;

    localparam logic [14:0] PATTERN_SEED    = 15'h7fff;
    localparam int          PATTERN_LOCK_COUNT = 32;
endpackage
`default_nettype wire

/* hdl/bit_clock_shaper.sv */
// Purpose: turns a per-bit strobe into a payload clock pulse and an overhead pulse
// Assumes: strobe is one pclk cycle wide, one per line bit
// Notes:   both outputs are registered, one cycle after the strobe
`default_nettype none
module bit_clock_shaper (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic bit_strobe,
    input  wire logic bit_is_overhead,
    input  wire logic gapped,
    output logic      clock_pulse,
    output logic      overhead_pulse
);
    logic clock_next;
    logic overhead_next;

    // gapped mode drops the edge on overhead bits, ungated mode flags them instead
    assign clock_next    = bit_strobe & ~(gapped & bit_is_overhead);
    assign overhead_next = bit_strobe & ~gapped & bit_is_overhead;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clock_pulse    <= 1'b0;
            overhead_pulse <= 1'b0;
        end else begin
            clock_pulse    <= clock_next;
            overhead_pulse <= overhead_next;
        end
    end
endmodule
`default_nettype wire

/* hdl/framer_channel_status_test_regs.sv */
// Purpose: per-channel block interrupt status, test register and receive status of a framer
// Assumes: all inputs synchronous to pclk; line bits arrive as one-cycle strobes
// Notes:   apb slave with one setup cycle and a zero-wait access phase
`default_nettype none
module framer_channel_status_test_regs #(
    parameter int RX_SOURCES = 8,
    parameter int TX_SOURCES = 4,
    parameter int LOCK_COUNT = framer_status_pkg::PATTERN_LOCK_COUNT
) (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [7:0]            paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    output logic                       irq,
    input  wire logic [RX_SOURCES-1:0] rx_source_pending,
    input  wire logic [RX_SOURCES-1:0] rx_source_enable,
    input  wire logic [TX_SOURCES-1:0] tx_source_pending,
    input  wire logic [TX_SOURCES-1:0] tx_source_enable,
    input  wire logic                  one_second_tick,
    input  wire logic                  alarm_detect,
    input  wire logic                  los_detect,
    input  wire logic                  idle_detect,
    input  wire logic                  oof_detect,
    output logic      [2:0]            framing_config,
    input  wire logic                  rx_bit_strobe,
    input  wire logic                  rx_bit_is_overhead,
    input  wire logic                  rx_bit_data,
    output logic                       rx_payload_clock_out,
    output logic                       rx_serial_payload_out,
    output logic                       rx_overhead_indicator,
    input  wire logic                  tx_bit_strobe,
    input  wire logic                  tx_next_is_overhead,
    input  wire logic                  tx_serial_payload_in,
    input  wire logic [3:0]            tx_nibble_payload_in,
    input  wire logic                  tx_overhead_in,
    input  wire logic                  tx_overhead_from_pin,
    input  wire logic                  tx_internal_overhead,
    input  wire logic [3:0]            tx_internal_overhead_nibble,
    output logic                       tx_overhead_bit_out,
    output logic      [3:0]            tx_overhead_nibble_out,
    output logic                       tx_overhead_indicator,
    output logic                       tx_pattern_bit,
    output logic                       overhead_input_select,
    output logic                       pattern_generator_enable,
    output logic                       pattern_receiver_enable,
    output logic                       pattern_lock_flag
);
    logic [7:0]  irq_enable_reg;
    logic [7:0]  test_reg;
    logic [2:0]  rx_cfg_reg;
    logic        one_sec_reg;
    logic        one_sec_next;
    logic [31:0] prdata_reg;
    logic [14:0] gen_lfsr_reg;
    logic [14:0] rx_shift_reg;
    logic [5:0]  match_count_reg;
    logic        lock_reg;

    logic       setup_phase;
    logic       access_done;
    logic       write_done;
    logic       hit_enable;
    logic       hit_status;
    logic       hit_test;
    logic       hit_rx_cfg;
    logic       hit_clear;
    logic       addr_hit;
    logic       rx_block_irq_pending;
    logic       tx_block_irq_pending;
    logic [7:0] status_word;
    logic [7:0] test_word;
    logic [7:0] rx_cfg_word;
    logic [7:0] read_mux;
    logic       status_read_done;
    logic       clear_one_sec;
    logic       rx_gapped;
    logic       tx_payload_clock;
    logic       tx_clock_pulse;
    logic       tx_overhead_pulse;
    logic       gen_feedback;
    logic       rx_predict;
    logic       rx_payload_strobe;
    logic       rx_match;

    // address decode and phases
    assign setup_phase = psel & ~penable;
    assign access_done = psel & penable;
    assign write_done  = access_done & pwrite;
    assign hit_enable  = paddr == framer_status_pkg::ADDR_BLOCK_IRQ_ENABLE;
    assign hit_status  = paddr == framer_status_pkg::ADDR_BLOCK_IRQ_STATUS;
    assign hit_test    = paddr == framer_status_pkg::ADDR_TEST_CONTROL;
    assign hit_rx_cfg  = paddr == framer_status_pkg::ADDR_RX_CONFIG_STATUS;
    assign hit_clear   = paddr == framer_status_pkg::ADDR_BLOCK_IRQ_CLEAR;
    assign addr_hit    = hit_enable | hit_status | hit_test | hit_rx_cfg | hit_clear;
    assign pready      = 1'b1;
    assign pslverr     = access_done & ~addr_hit;
    assign prdata      = prdata_reg;

    // section summaries are levels; the host clears them at the source
    assign rx_block_irq_pending = |(rx_source_pending & rx_source_enable);
    assign tx_block_irq_pending = |(tx_source_pending & tx_source_enable);

    assign status_word = {rx_block_irq_pending, 5'h00, tx_block_irq_pending, one_sec_reg};
    assign irq         = |(status_word & irq_enable_reg);

    // lock is only meaningful with both pattern blocks on, so it is masked otherwise
    assign pattern_lock_flag = lock_reg & test_reg[framer_status_pkg::BIT_PAT_GEN_EN]
                             & test_reg[framer_status_pkg::BIT_PAT_RX_EN];
    assign test_word   = {test_reg[7:5], pattern_lock_flag, test_reg[3:2], 2'b00};
    assign rx_cfg_word = {alarm_detect, los_detect, idle_detect, oof_detect, 1'b0, rx_cfg_reg};

    assign read_mux = hit_enable ? irq_enable_reg :
                      hit_status ? status_word :
                      hit_test   ? test_word :
                      hit_rx_cfg ? rx_cfg_word : 8'h00;

    // read data is captured in setup so the answer comes from a flip-flop without a wait state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h00000000;
        end else if (setup_phase && !pwrite) begin
            prdata_reg <= {24'h000000, read_mux};
        end
    end

    // one-second flag: the tick wins over a clear arriving in the same cycle
    // a read clears only what it returned, so a tick landing at the setup edge is not lost
    assign status_read_done = access_done & ~pwrite & hit_status;
    assign clear_one_sec    = (status_read_done & prdata_reg[framer_status_pkg::BIT_ONE_SEC])
                            | (write_done & hit_clear & pwdata[framer_status_pkg::BIT_ONE_SEC]);
    assign one_sec_next     = one_second_tick | (one_sec_reg & ~clear_one_sec);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            one_sec_reg <= 1'b0;
        end else begin
            one_sec_reg <= one_sec_next;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_enable_reg <= framer_status_pkg::RESET_VALUE;
            test_reg       <= framer_status_pkg::RESET_VALUE;
            rx_cfg_reg     <= 3'h0;
        end else if (write_done) begin
            if (hit_enable) begin
                irq_enable_reg <= pwdata[7:0] & framer_status_pkg::IRQ_ENABLE_MASK;
            end
            if (hit_test) begin
                test_reg <= pwdata[7:0] & framer_status_pkg::TEST_WRITE_MASK;
            end
            if (hit_rx_cfg) begin
                rx_cfg_reg <= pwdata[2:0];
            end
        end
    end

    assign framing_config           = rx_cfg_reg;
    assign overhead_input_select    = test_reg[framer_status_pkg::BIT_OH_SELECT];
    assign rx_gapped                = test_reg[framer_status_pkg::BIT_RX_GAPPED];
    assign tx_payload_clock         = test_reg[framer_status_pkg::BIT_TX_PAYCLK];
    assign pattern_receiver_enable  = test_reg[framer_status_pkg::BIT_PAT_RX_EN];
    assign pattern_generator_enable = test_reg[framer_status_pkg::BIT_PAT_GEN_EN];

    // overhead source for the transmitter
    assign tx_overhead_bit_out = overhead_input_select ? tx_serial_payload_in :
                                 (tx_overhead_from_pin ? tx_overhead_in : tx_internal_overhead);
    assign tx_overhead_nibble_out = overhead_input_select ? tx_nibble_payload_in
                                                          : tx_internal_overhead_nibble;

    // receive payload clock and overhead flag
    bit_clock_shaper rx_shaper (
        .pclk            (pclk),
        .presetn         (presetn),
        .bit_strobe      (rx_bit_strobe),
        .bit_is_overhead (rx_bit_is_overhead),
        .gapped          (rx_gapped),
        .clock_pulse     (rx_payload_clock_out),
        .overhead_pulse  (rx_overhead_indicator)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_serial_payload_out <= 1'b0;
        end else if (rx_bit_strobe) begin
            rx_serial_payload_out <= rx_bit_data;
        end
    end

    // transmit side looks one bit ahead, so the pulse leads the overhead bit
    bit_clock_shaper tx_shaper (
        .pclk            (pclk),
        .presetn         (presetn),
        .bit_strobe      (tx_bit_strobe),
        .bit_is_overhead (tx_next_is_overhead),
        .gapped          (tx_payload_clock),
        .clock_pulse     (tx_clock_pulse),
        .overhead_pulse  (tx_overhead_pulse)
    );

    // in payload-clock mode the equipment changes data on the falling side of this pulse
    assign tx_overhead_indicator = tx_payload_clock ? tx_clock_pulse : tx_overhead_pulse;

    // pattern generator, advancing once per transmit bit while enabled
    assign gen_feedback = gen_lfsr_reg[14] ^ gen_lfsr_reg[13];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gen_lfsr_reg   <= framer_status_pkg::PATTERN_SEED;
            tx_pattern_bit <= 1'b0;
        end else if (pattern_generator_enable && tx_bit_strobe) begin
            gen_lfsr_reg   <= {gen_lfsr_reg[13:0], gen_feedback};
            tx_pattern_bit <= gen_feedback;
        end
    end

    // self-synchronising pattern receiver on payload bits only
    assign rx_payload_strobe = pattern_receiver_enable & rx_bit_strobe & ~rx_bit_is_overhead;
    assign rx_predict        = rx_shift_reg[14] ^ rx_shift_reg[13];
    assign rx_match          = rx_predict == rx_bit_data;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_shift_reg    <= 15'h0000;
            match_count_reg <= 6'h00;
            lock_reg        <= 1'b0;
        end else if (!pattern_receiver_enable) begin
            match_count_reg <= 6'h00;
            lock_reg        <= 1'b0;
        end else if (rx_payload_strobe) begin
            rx_shift_reg <= {rx_shift_reg[13:0], rx_bit_data};
            if (!rx_match) begin
                match_count_reg <= 6'h00;
                lock_reg        <= 1'b0;
            end else if (32'(match_count_reg) + 1 >= LOCK_COUNT) begin
                lock_reg <= 1'b1;
            end else begin
                match_count_reg <= match_count_reg + 6'h01;
            end
        end
    end

    // checks
    a_rx_block_read: assert property (@(posedge pclk) disable iff (!presetn)
        (setup_phase && !pwrite && hit_status) |=> prdata[7] == $past(|(rx_source_pending & rx_source_enable)))
        else $error("rx block status read wrong");

    a_tx_block_read: assert property (@(posedge pclk) disable iff (!presetn)
        (setup_phase && !pwrite && hit_status) |=> prdata[1] == $past(|(tx_source_pending & tx_source_enable)))
        else $error("tx block status read wrong");

    a_one_sec_clear: assert property (@(posedge pclk) disable iff (!presetn)
        (status_read_done && prdata[framer_status_pkg::BIT_ONE_SEC] && !one_second_tick) |=> !one_sec_reg)
        else $error("one-second bit not cleared by read");

    a_one_sec_keep: assert property (@(posedge pclk) disable iff (!presetn)
        (status_read_done && !prdata[framer_status_pkg::BIT_ONE_SEC] && one_sec_reg) |=> one_sec_reg)
        else $error("unreported one-second bit cleared by read");

    a_one_sec_set: assert property (@(posedge pclk) disable iff (!presetn)
        one_second_tick |=> one_sec_reg ##1 (one_sec_reg || $past(clear_one_sec)))
        else $error("one-second tick lost");

    a_oh_source: assert property (@(posedge pclk) disable iff (!presetn)
        (overhead_input_select && tx_bit_strobe) |-> tx_overhead_bit_out == tx_serial_payload_in)
        else $error("overhead not taken from payload input");

    a_rx_gap_oh: assert property (@(posedge pclk) disable iff (!presetn)
        (rx_gapped && rx_bit_strobe && rx_bit_is_overhead && $stable(rx_gapped)) |=> !rx_payload_clock_out)
        else $error("rx clock edge on overhead in gapped mode");

    a_rx_oh_flag: assert property (@(posedge pclk) disable iff (!presetn)
        (!rx_gapped && rx_bit_strobe && rx_bit_is_overhead) |=> rx_payload_clock_out && rx_overhead_indicator)
        else $error("rx overhead bit not clocked and flagged");

    a_tx_oh_lead: assert property (@(posedge pclk) disable iff (!presetn)
        (!tx_payload_clock && tx_bit_strobe && tx_next_is_overhead && $stable(test_reg))
        |=> tx_overhead_indicator)
        else $error("tx overhead pulse missing");

    a_tx_gap_oh: assert property (@(posedge pclk) disable iff (!presetn)
        (tx_payload_clock && tx_bit_strobe && tx_next_is_overhead && $stable(test_reg))
        |=> !tx_overhead_indicator)
        else $error("tx payload clock edge on overhead bit");

    a_lock_valid: assert property (@(posedge pclk) disable iff (!presetn)
        pattern_lock_flag |-> (pattern_generator_enable && pattern_receiver_enable))
        else $error("lock flag shown without both enables");

    a_rx_pat_off: assert property (@(posedge pclk) disable iff (!presetn)
        !pattern_receiver_enable |=> !lock_reg && match_count_reg == 6'h00)
        else $error("pattern receiver active while disabled");

    a_gen_hold: assert property (@(posedge pclk) disable iff (!presetn)
        !pattern_generator_enable |=> $stable(gen_lfsr_reg))
        else $error("pattern generator moved while disabled");

    a_alarm_read: assert property (@(posedge pclk) disable iff (!presetn)
        (setup_phase && !pwrite && hit_rx_cfg) |=> prdata[7] == $past(alarm_detect))
        else $error("alarm bit read wrong");

    a_los_read: assert property (@(posedge pclk) disable iff (!presetn)
        (setup_phase && !pwrite && hit_rx_cfg) |=> prdata[6] == $past(los_detect))
        else $error("loss of signal bit read wrong");
endmodule
`default_nettype wire

/* bench/terminal_model.sv */
// Purpose: terminal equipment on the transmit payload port
// Assumes: payload clock arrives on the tx overhead indicator as one-cycle pulses
// Notes:   new data only on a falling payload clock edge, so the device never sees it move mid-bit
`default_nettype none
module terminal_model (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       payload_clock_mode,
    input  wire logic       tx_overhead_indicator,
    output logic            tx_serial_payload_in,
    output logic      [3:0] tx_nibble_payload_in
);
    logic       clk_prev_reg;
    logic [3:0] count_reg;
    wire logic  clk_fall = clk_prev_reg & ~tx_overhead_indicator;
    assign tx_serial_payload_in = count_reg[0];
    assign tx_nibble_payload_in = count_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_prev_reg <= 1'b0;
            count_reg    <= 4'h0;
        end else begin
            clk_prev_reg <= tx_overhead_indicator;
            if (payload_clock_mode && clk_fall) begin
                count_reg <= count_reg + 4'h1;
            end
        end
    end
endmodule
`default_nettype wire

/* bench/tb_top.sv */
// Purpose: self-checking bench for the channel status and test registers
// Assumes: zero-wait apb slave; lock count shortened to 4
// Notes:   source-level reads are stood in for by dropping the pending inputs
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, irq, err;
    logic [7:0] paddr = 8'h00, rx_source_pending = 8'h00, rx_source_enable = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0] tx_source_pending = 4'h0, tx_source_enable = 4'h0, tx_internal_overhead_nibble = 4'h0;
    logic one_second_tick = 0, alarm_detect = 0, los_detect = 0, idle_detect = 0, oof_detect = 0;
    logic rx_bit_strobe = 0, rx_bit_is_overhead = 0, rx_bit_data = 0, tx_bit_strobe = 0;
    logic tx_next_is_overhead = 0, tx_overhead_in = 0, tx_overhead_from_pin = 0;
    logic tx_internal_overhead = 0, payclk_mode = 0;
    logic [2:0] framing_config;
    logic [3:0] tx_nibble_payload_in, tx_overhead_nibble_out, n0;
    logic [2:0] seen;
    logic rx_payload_clock_out, rx_serial_payload_out, rx_overhead_indicator, tx_serial_payload_in;
    logic tx_overhead_bit_out, tx_overhead_indicator, tx_pattern_bit, overhead_input_select;
    logic pattern_generator_enable, pattern_receiver_enable, pattern_lock_flag;
    int error_cnt = 0, num_checks = 0, cycles = 0, toggles;
    always #10 pclk = ~pclk;
    framer_channel_status_test_regs #(.RX_SOURCES(8), .TX_SOURCES(4), .LOCK_COUNT(4)) DUT (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irq,
        .rx_source_pending, .rx_source_enable, .tx_source_pending, .tx_source_enable, .one_second_tick,
        .alarm_detect, .los_detect, .idle_detect, .oof_detect, .framing_config, .rx_bit_strobe,
        .rx_bit_is_overhead, .rx_bit_data, .rx_payload_clock_out, .rx_serial_payload_out,
        .rx_overhead_indicator, .tx_bit_strobe, .tx_next_is_overhead, .tx_serial_payload_in,
        .tx_nibble_payload_in, .tx_overhead_in, .tx_overhead_from_pin, .tx_internal_overhead,
        .tx_internal_overhead_nibble, .tx_overhead_bit_out, .tx_overhead_nibble_out, .tx_overhead_indicator,
        .tx_pattern_bit, .overhead_input_select, .pattern_generator_enable, .pattern_receiver_enable,
        .pattern_lock_flag);
    terminal_model partner (.pclk, .presetn, .payload_clock_mode(payclk_mode), .tx_overhead_indicator,
        .tx_serial_payload_in, .tx_nibble_payload_in);
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // one transfer; entered just after a rising edge, returns just after one
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(nm, exp, rd);
    endtask
    // strobes: rx strobe, rx overhead, rx data, tx strobe, tx next overhead
    // the one-cycle output pulses are caught mid-cycle, while they stand
    task automatic step(input logic [4:0] v);
        {rx_bit_strobe, rx_bit_is_overhead, rx_bit_data, tx_bit_strobe, tx_next_is_overhead} <= v;
        @(posedge pclk);
        rx_bit_strobe <= 1'b0;
        tx_bit_strobe <= 1'b0;
        @(negedge pclk);
        seen = {rx_payload_clock_out, rx_overhead_indicator, tx_overhead_indicator};
        @(posedge pclk);
    endtask
    task automatic t_reset();
        for (int i = 0; i < 5; i++) rdchk("reset value", 8'h04 + 8'(4 * i), 32'h0);
        apb(1'b0, 8'h20, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, err});
        chk("unmapped data", 32'h0, rd);
    endtask
    task automatic t_block();
        rx_source_pending <= 8'h10;
        rdchk("rx disabled source", 8'h08, 32'h00);
        rx_source_enable <= 8'h10;
        rdchk("rx block bit", 8'h08, 32'h80);
        rdchk("rx not cleared by read", 8'h08, 32'h80);
        tx_source_pending <= 4'h2;
        tx_source_enable <= 4'h2;
        rdchk("tx block bit", 8'h08, 32'h82);
        apb(1'b1, 8'h04, 32'h82);
        chk("irq on", 32'h1, {31'h0, irq});
        rx_source_pending <= 8'h00;
        rdchk("rx cleared at source", 8'h08, 32'h02);
        tx_source_pending <= 4'h0;
        rdchk("tx cleared at source", 8'h08, 32'h00);
        chk("irq off", 32'h0, {31'h0, irq});
    endtask
    task automatic t_second();
        apb(1'b1, 8'h04, 32'h01);
        one_second_tick <= 1'b1;
        @(posedge pclk);
        one_second_tick <= 1'b0;
        @(posedge pclk);
        chk("second irq", 32'h1, {31'h0, irq});
        rdchk("second set", 8'h08, 32'h01);
        rdchk("second cleared", 8'h08, 32'h00);
        chk("second irq gone", 32'h0, {31'h0, irq});
        one_second_tick <= 1'b1;
        @(posedge pclk);
        one_second_tick <= 1'b0;
        apb(1'b1, 8'h14, 32'h01);
        rdchk("clear register", 8'h08, 32'h00);
        apb(1'b1, 8'h04, 32'h00);
    endtask
    task automatic t_test();
        apb(1'b1, 8'h0c, 32'hff);
        rdchk("test write mask", 8'h0c, 32'hec);
        chk("outputs", 32'h7, {29'h0, overhead_input_select, pattern_generator_enable, pattern_receiver_enable});
        chk("oh from payload", {28'h0, tx_nibble_payload_in}, {28'h0, tx_overhead_nibble_out});
        chk("oh bit payload", {31'h0, tx_serial_payload_in}, {31'h0, tx_overhead_bit_out});
        apb(1'b1, 8'h0c, 32'h00);
        {tx_overhead_from_pin, tx_overhead_in, tx_internal_overhead} <= 3'b110;
        tx_internal_overhead_nibble <= 4'h5;
        @(posedge pclk);
        chk("oh from pin", 32'h15, {27'h0, tx_overhead_bit_out, tx_overhead_nibble_out});
        tx_overhead_from_pin <= 1'b0;
        @(posedge pclk);
        chk("oh internal", 32'h05, {27'h0, tx_overhead_bit_out, tx_overhead_nibble_out});
    endtask
    task automatic t_lines();
        for (int g = 0; g < 2; g++) begin
            apb(1'b1, 8'h0c, 32'(g) << 6);
            step(5'b11100);
            chk("rx oh bit", {30'h0, ~g[0], ~g[0]}, {30'h0, seen[2:1]});
            chk("rx oh data", 32'h1, {31'h0, rx_serial_payload_out});
            step(5'b10000);
            chk("rx payload bit", 32'h2, {30'h0, seen[2:1]});
        end
        apb(1'b1, 8'h0c, 32'h00);
        step(5'b00011);
        chk("tx indicator oh", 32'h1, {31'h0, seen[0]});
        step(5'b00010);
        chk("tx indicator pay", 32'h0, {31'h0, seen[0]});
        apb(1'b1, 8'h0c, 32'h20);
        payclk_mode <= 1'b1;
        n0 = tx_nibble_payload_in;
        for (int i = 0; i < 6; i++) begin
            step({3'b000, 1'b1, i % 3 == 0});
            chk("tx payload clock", 32'(i % 3 != 0), {31'h0, seen[0]});
        end
        repeat (2) @(posedge pclk);
        chk("terminal bits", {28'h0, n0 + 4'h4}, {28'h0, tx_nibble_payload_in});
        payclk_mode <= 1'b0;
    endtask
    task automatic t_pattern();
        logic p;
        for (int k = 0; k < 2; k++) begin
            apb(1'b1, 8'h0c, k ? 32'h0c : 32'h04);
            toggles = 0;
            repeat (40) begin
                p = tx_pattern_bit;
                step({2'b10, p, 2'b10});
                toggles += int'(p != tx_pattern_bit);
            end
            chk("generator runs", 32'h1, {31'h0, toggles > 0});
            chk("lock flag", 32'(k), {31'h0, pattern_lock_flag});
        end
        rdchk("lock readback", 8'h0c, 32'h1c);
        apb(1'b1, 8'h0c, 32'h08);
        chk("lock needs generator", 32'h0, {31'h0, pattern_lock_flag});
        p = tx_pattern_bit;
        repeat (20) step(5'b00010);
        chk("generator stopped", {31'h0, p}, {31'h0, tx_pattern_bit});
    endtask
    task automatic t_status();
        apb(1'b1, 8'h10, 32'hff);
        for (int i = 0; i < 4; i++) begin
            {alarm_detect, los_detect, idle_detect, oof_detect} <= 4'h8 >> i;
            rdchk("rx status", 8'h10, (32'h80 >> i) | 32'h07);
        end
        chk("framing config", 32'h7, {29'h0, framing_config});
    endtask
    task automatic complete_run();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // ceiling well above the few hundred cycles the scenarios need
    always @(posedge pclk) begin
        cycles++;
        if (cycles > 20000) begin
            error_cnt++;
            complete_run();
        end
    end
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_block();
        t_second();
        t_test();
        t_lines();
        t_pattern();
        t_status();
        complete_run();
    end
endmodule
`default_nettype wire
